// ===== hdl/ccr_consts.svh
`ifndef CCR_CONSTS_SVH
`define CCR_CONSTS_SVH
// ==========================================================================
// register map
`define CCR_ADDR_STATUS     8'h01
`define CCR_ADDR_SPECIAL    8'h08
`define CCR_ADDR_CUR_HI     8'h0E
`define CCR_ADDR_CUR_LO     8'h0F
`define CCR_ADDR_CHG_HI     8'h10
`define CCR_ADDR_CHG_LO     8'h11
// ==========================================================================
// reset values and field positions
`define CCR_STATUS_RST      8'h00
`define CCR_STATUS_WMASK    8'h50
`define CCR_SPECIAL_RST     8'h40
`define CCR_SPECIAL_WMASK   8'h40
`define CCR_ZERO8           8'h00
`define CCR_ZERO16          16'h0000
// ==========================================================================
// timing: conversion periods in microseconds, clock 40 MHz
`define CCR_CLK_MHZ         40
`define CCR_PERIOD_HI_US    3500000
`define CCR_PERIOD_LO_US    875000
`define CCR_OFFSET_EVERY    1024
// accumulator fraction: each result added at the fraction LSB, i.e. divided by 1024
`define CCR_FRAC_BITS       10
`endif

// ===== hdl/ccr_pkg.sv
package ccr_pkg;
  // ========================================================================
  // conversion sequencer states
  typedef enum logic [2:0] {
    CCR_MEAS   = 3'b001,  // normal sense conversion
    CCR_OFFSET = 3'b010,  // offset calibration conversion
    CCR_SKIP   = 3'b100   // never entered; the write-forced conversion runs as CCR_OFFSET
  } ccr_conv_e;
endpackage : ccr_pkg

// ===== hdl/ccr_hold_pair.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================================
// two-byte snapshot: captures live word on high-byte read, holds to cmd end
module ccr_hold_pair #(
  parameter int W = 16  // word width
) (
  input  wire logic         clock,    // system clock
  input  wire logic         rstn,     // sync reset, active low
  input  wire logic         ce,       // clock enable
  input  wire logic         capture,  // high byte read strobe
  input  wire logic         release_i, // read command ended
  input  wire logic [W-1:0] live,     // live register value
  output logic      [W-1:0] view      // value presented to reads
);
  logic [W-1:0] snap_ff;  // frozen copy
  logic         held_ff;  // snapshot valid
  // snapshot process
  always_ff @(posedge clock) begin
    if (!rstn) begin
      snap_ff <= '0;
      held_ff <= 1'b0;
    end else if (ce) begin
      if (capture) begin
        snap_ff <= live;
        held_ff <= 1'b1;
      end else if (release_i) begin
        held_ff <= 1'b0;
      end
    end
  end
  // high-byte reads see the capture cycle value too
  assign view = (held_ff && !capture) ? snap_ff : live;
endmodule : ccr_hold_pair
`default_nettype wire

// ===== hdl/ccr_regs.sv
`timescale 1ns/1ps
`default_nettype none
`include "ccr_consts.svh"
module ccr_regs #(
  parameter bit HIGH_RES  = 1'b1,                  // 1 = 15-bit, 0 = 13-bit variant
  parameter int PERIOD_HI = `CCR_PERIOD_HI_US * `CCR_CLK_MHZ, // cycles, high res
  parameter int PERIOD_LO = `CCR_PERIOD_LO_US * `CCR_CLK_MHZ, // cycles, low res
  parameter int OFS_EVERY = `CCR_OFFSET_EVERY      // offset cycle spacing
) (
  input  wire logic               clock,       // system clock, 40 MHz
  input  wire logic               rstn,        // sync reset, active low
  input  wire logic               ce,          // clock enable
  input  wire logic               active,      // power mode active
  input  wire logic signed [15:0] adc_raw,     // raw converter word, two's complement
  input  wire logic signed [15:0] adc_offset,  // raw offset reading
  input  wire logic [7:0]         reg_addr,    // register address
  input  wire logic               reg_rd,      // read strobe
  input  wire logic               reg_wr,      // write strobe
  input  wire logic [7:0]         reg_wdata,   // write data
  input  wire logic               cmd_end,     // read command finished
  output logic [7:0]              reg_rdata,   // read data, registered
  output logic                    conv_done,   // pulse per completed conversion
  output logic                    offset_cyc   // level: offset conversion running
);
  // ========================================================================
  // declarations
  localparam int PERIOD = HIGH_RES ? PERIOD_HI : PERIOD_LO; // cycles per conversion
  localparam int FB     = `CCR_FRAC_BITS;                   // hidden fraction width

  logic [31:0]        tick_ff;        // conversion period timer
  logic [10:0]        conv_cnt_ff;    // conversions since last offset
  ccr_pkg::ccr_conv_e state_ff;       // what the running conversion is
  ccr_pkg::ccr_conv_e nxt_state;      // next conversion kind
  logic               skip_ff;        // running offset was forced by a write
  logic signed [15:0] offset_ff;      // correction factor
  logic signed [15:0] current_ff;     // current result
  logic signed [15:0] charge_ff;      // charge total, visible part
  logic [FB-1:0]      frac_ff;        // hidden fraction
  logic [7:0]         status_ff;      // status/control byte
  logic [7:0]         special_ff;     // special feature byte
  logic [7:0]         chg_wr_hi_ff;   // staged high byte of a charge write
  logic [7:0]         rdata_ff;       // read data
  logic               done_ff;        // conversion done pulse
  logic               end_conv;       // period boundary this cycle
  logic signed [15:0] corrected;      // raw minus offset, clipped to variant
  logic signed [16+FB:0] acc_sum;     // wide accumulate sum
  logic [15:0]        cur_view;       // current pair as read
  logic [15:0]        chg_view;       // charge pair as read
  logic               cur_cap;        // high-byte read of current
  logic               chg_cap;        // high-byte read of charge
  logic               chg_write;      // charge low byte written

  assign end_conv  = active && (tick_ff == 32'(PERIOD - 1));
  assign chg_write = reg_wr && (reg_addr == `CCR_ADDR_CHG_LO);
  assign cur_cap   = reg_rd && (reg_addr == `CCR_ADDR_CUR_HI);
  assign chg_cap   = reg_rd && (reg_addr == `CCR_ADDR_CHG_HI);

  // ========================================================================
  // conversion timer; cleared while asleep
  always_ff @(posedge clock) begin
    if (!rstn) begin
      tick_ff <= 32'h0000_0000;
    end else if (ce) begin
      if (!active) begin
        tick_ff <= 32'h0000_0000;
      end else if (end_conv || chg_write) begin
        // a charge write restarts the period so the forced offset is whole
        tick_ff <= 32'h0000_0000;
      end else begin
        tick_ff <= tick_ff + 32'h0000_0001;
      end
    end
  end

  // ========================================================================
  // which kind the next conversion is
  always_comb begin
    nxt_state = ccr_pkg::CCR_MEAS;
    case (state_ff)
      ccr_pkg::CCR_OFFSET: begin
        // measuring resumes with the conversion right after the offset
        nxt_state = ccr_pkg::CCR_MEAS;
      end
      ccr_pkg::CCR_MEAS, ccr_pkg::CCR_SKIP: begin
        if (conv_cnt_ff == 11'(OFS_EVERY - 2)) begin
          nxt_state = ccr_pkg::CCR_OFFSET;
        end
      end
      default: nxt_state = ccr_pkg::CCR_MEAS;
    endcase
  end

  // sequencer state and counters
  always_ff @(posedge clock) begin
    if (!rstn) begin
      state_ff    <= ccr_pkg::CCR_MEAS;
      conv_cnt_ff <= 11'h000;
    end else if (ce) begin
      if (chg_write) begin
        // the conversion started by the write is the forced offset one
        state_ff    <= ccr_pkg::CCR_OFFSET;
        conv_cnt_ff <= 11'h000;
      end else if (end_conv) begin
        state_ff <= nxt_state;
        if (nxt_state == ccr_pkg::CCR_OFFSET) begin
          conv_cnt_ff <= 11'h000;
        end else begin
          conv_cnt_ff <= conv_cnt_ff + 11'h001; // 1022 normal per offset
        end
      end
    end
  end

  // forced-offset flag; set by write wins over consumption
  always_ff @(posedge clock) begin
    if (!rstn) begin
      skip_ff <= 1'b0;
    end else if (ce) begin
      if (chg_write) begin
        skip_ff <= 1'b1;
      end else if (end_conv) begin
        if (state_ff == ccr_pkg::CCR_OFFSET) begin
          skip_ff <= 1'b0;
        end
      end
    end
  end

  // ========================================================================
  // offset correction factor captured at end of offset conversion
  always_ff @(posedge clock) begin
    if (!rstn) begin
      offset_ff <= 16'sh0000;
    end else if (ce && end_conv && state_ff == ccr_pkg::CCR_OFFSET) begin
      offset_ff <= adc_offset;
    end
  end

  // corrected result; low-res variant drops two bits of resolution
  always_comb begin
    corrected = adc_raw - offset_ff;
    if (!HIGH_RES) begin
      corrected = {corrected[15:2], 2'b00};
    end
  end

  // current register
  always_ff @(posedge clock) begin
    if (!rstn) begin
      current_ff <= 16'sh0000;
    end else if (ce && end_conv && state_ff != ccr_pkg::CCR_OFFSET) begin
      current_ff <= corrected;        // kept during offset
    end
  end

  // ========================================================================
  // accumulator: result added at the hidden fraction LSB, scaled by 1/1024
  assign acc_sum = $signed({charge_ff, frac_ff}) +
                   (state_ff == ccr_pkg::CCR_OFFSET ? (17+FB)'(current_ff)
                                                    : (17+FB)'(corrected));

  always_ff @(posedge clock) begin
    if (!rstn) begin
      charge_ff    <= 16'sh0000;
      frac_ff      <= '0;
      chg_wr_hi_ff <= `CCR_ZERO8;
    end else if (ce) begin
      if (reg_wr && reg_addr == `CCR_ADDR_CHG_HI) begin
        chg_wr_hi_ff <= reg_wdata;
      end
      if (chg_write) begin
        charge_ff <= {chg_wr_hi_ff, reg_wdata};
        frac_ff   <= '0;
      end else if (end_conv && !(state_ff == ccr_pkg::CCR_OFFSET && skip_ff)) begin
        charge_ff <= acc_sum[15+FB:FB];
        frac_ff   <= acc_sum[FB-1:0];
      end
    end
  end

  // ========================================================================
  // status and special feature bytes
  always_ff @(posedge clock) begin
    if (!rstn) begin
      status_ff  <= `CCR_STATUS_RST;
      special_ff <= `CCR_SPECIAL_RST;
    end else if (ce && reg_wr) begin
      if (reg_addr == `CCR_ADDR_STATUS) begin
        status_ff <= reg_wdata & `CCR_STATUS_WMASK;
      end
      if (reg_addr == `CCR_ADDR_SPECIAL) begin
        special_ff <= reg_wdata & `CCR_SPECIAL_WMASK;
      end
    end
  end

  // ========================================================================
  // coherent two-byte reads
  ccr_hold_pair #(.W(16)) u_cur_hold (
    .clock     (clock),
    .rstn      (rstn),
    .ce        (ce),
    .capture   (cur_cap),
    .release_i (cmd_end),
    .live      (current_ff),
    .view      (cur_view)
  );

  ccr_hold_pair #(.W(16)) u_chg_hold (
    .clock     (clock),
    .rstn      (rstn),
    .ce        (ce),
    .capture   (chg_cap),
    .release_i (cmd_end),
    .live      (charge_ff),
    .view      (chg_view)
  );

  // read data, unmapped addresses read zero
  always_ff @(posedge clock) begin
    if (!rstn) begin
      rdata_ff <= `CCR_ZERO8;
    end else if (ce && reg_rd) begin
      case (reg_addr)
        `CCR_ADDR_STATUS:  rdata_ff <= status_ff;
        `CCR_ADDR_SPECIAL: rdata_ff <= special_ff;
        `CCR_ADDR_CUR_HI:  rdata_ff <= cur_view[15:8];
        `CCR_ADDR_CUR_LO:  rdata_ff <= cur_view[7:0];
        `CCR_ADDR_CHG_HI:  rdata_ff <= chg_view[15:8];
        `CCR_ADDR_CHG_LO:  rdata_ff <= chg_view[7:0];
        default:           rdata_ff <= `CCR_ZERO8;
      endcase
    end
  end

  // conversion done pulse and offset level
  always_ff @(posedge clock) begin
    if (!rstn) begin
      done_ff <= 1'b0;
    end else if (ce) begin
      done_ff <= end_conv;
    end
  end

  assign reg_rdata  = rdata_ff;
  assign conv_done  = done_ff;
  assign offset_cyc = (state_ff == ccr_pkg::CCR_OFFSET);
endmodule : ccr_regs
`default_nettype wire

// ===== testbench/ccr_regs_props.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================================
// port checker for the charge register block
module ccr_regs_props #(
  parameter bit HIGH_RES  = 1'b1,  // resolution variant
  parameter int PERIOD_HI = 20,    // cycles per period
  parameter int PERIOD_LO = 20,    // cycles per period
  parameter int OFS_EVERY = 1024   // offset spacing
) (
  input wire logic               clock,      // clock
  input wire logic               rstn,       // sync reset
  input wire logic               ce,         // enable
  input wire logic               active,     // power mode
  input wire logic signed [15:0] adc_raw,    // sense word
  input wire logic signed [15:0] adc_offset, // offset word
  input wire logic [7:0]         reg_addr,   // address
  input wire logic               reg_rd,     // read
  input wire logic               reg_wr,     // write
  input wire logic [7:0]         reg_wdata,  // write data
  input wire logic               cmd_end,    // command end
  input wire logic [7:0]         reg_rdata,  // read data
  input wire logic               conv_done,  // period pulse
  input wire logic               offset_cyc  // offset running
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rstn);
  // ========================================================================
  // helpers: conversions since a charge commit, 3 means idle so the
  // very first periods after reset are not judged
  logic [1:0] cnt_ff;  // saturating conversion count
  logic       seen_ff; // offset conversion seen since commit
  always_ff @(posedge clock) begin
    if (!rstn) begin
      cnt_ff  <= 2'd3;
      seen_ff <= 1'b0;
    end else if (ce && reg_wr && reg_addr == 8'h11) begin
      cnt_ff  <= 2'd0;
      seen_ff <= 1'b0;
    end else begin
      if (conv_done && cnt_ff != 2'd3) begin
        cnt_ff <= cnt_ff + 2'd1;
      end
      seen_ff <= seen_ff | offset_cyc;
    end
  end
  // ========================================================================
  // properties
  sequence s_wr(a);
    ce && reg_wr && reg_addr == a;
  endsequence
  sequence s_rd(a);
    ce && reg_rd && reg_addr == a;
  endsequence
  property p_done_gap;
    conv_done |=> !conv_done [*8];
  endproperty
  property p_sleep;
    !active ##1 !active |-> !conv_done;
  endproperty
  property p_unmapped;
    ce && reg_rd && (reg_addr inside {8'h00, [8'h02:8'h07], [8'h09:8'h0d], [8'h12:8'hff]})
      |=> reg_rdata == 8'h00;
  endproperty
  property p_rdata_hold;
    !(ce && reg_rd) |=> $stable(reg_rdata);
  endproperty
  property p_chg_offset;
    conv_done && cnt_ff == 2'd1 |-> seen_ff || offset_cyc;
  endproperty
  property p_ofs_hold;
    $rose(offset_cyc) |=> offset_cyc [*8];
  endproperty
  property p_status_mask;
    s_wr(8'h01) ##1 s_rd(8'h01) |=> reg_rdata == ($past(reg_wdata, 2) & 8'h50);
  endproperty
  property p_special_mask;
    s_wr(8'h08) ##1 s_rd(8'h08) |=> reg_rdata == ($past(reg_wdata, 2) & 8'h40);
  endproperty
  a_done_gap: assert property (p_done_gap)
    else $error("conversion pulses too close");
  a_sleep: assert property (p_sleep)
    else $error("conversion ended while asleep");
  a_unmapped: assert property (p_unmapped)
    else $error("reserved address read not zero");
  a_rdata_hold: assert property (p_rdata_hold)
    else $error("read data moved without a read");
  a_chg_offset: assert property (p_chg_offset)
    else $error("no offset conversion after charge write");
  a_ofs_hold: assert property (p_ofs_hold)
    else $error("offset conversion too short");
  a_status_mask: assert property (p_status_mask)
    else $error("status readback wrong");
  a_special_mask: assert property (p_special_mask)
    else $error("special readback wrong");
endmodule : ccr_regs_props
bind ccr_regs ccr_regs_props #(
  .HIGH_RES(HIGH_RES), .PERIOD_HI(PERIOD_HI), .PERIOD_LO(PERIOD_LO), .OFS_EVERY(OFS_EVERY)
) u_ccr_regs_props (
  .clock(clock), .rstn(rstn), .ce(ce), .active(active), .adc_raw(adc_raw),
  .adc_offset(adc_offset), .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_wr(reg_wr),
  .reg_wdata(reg_wdata), .cmd_end(cmd_end), .reg_rdata(reg_rdata),
  .conv_done(conv_done), .offset_cyc(offset_cyc)
);
`default_nettype wire

// ===== testbench/ccr_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================================
// host side: issues register cycles, one per clock, changed after the edge
module ccr_host_model (
  input  wire logic clock,     // system clock
  output logic [7:0] reg_addr,  // register address
  output logic       reg_rd,    // read strobe
  output logic       reg_wr,    // write strobe
  output logic [7:0] reg_wdata, // write data
  output logic       cmd_end    // read command over
);
  initial begin
    reg_addr  = 8'h00;
    reg_rd    = 1'b0;
    reg_wr    = 1'b0;
    reg_wdata = 8'h00;
    cmd_end   = 1'b0;
  end
  // one request held until the taking edge; callers chain these so that
  // high and low byte share one command before cmd_end
  task automatic drive(input logic [7:0] a, input logic r, input logic w,
                       input logic [7:0] d, input logic e);
    reg_addr  = a;
    reg_rd    = r;
    reg_wr    = w;
    reg_wdata = d;
    cmd_end   = e;
    @(posedge clock);
    #2;
  endtask : drive
  // release: data line shows the inverse so stale data cannot pass
  task automatic idle();
    reg_rd    = 1'b0;
    reg_wr    = 1'b0;
    cmd_end   = 1'b0;
    reg_wdata = ~reg_wdata;
    @(posedge clock);
    #2;
  endtask : idle
endmodule : ccr_host_model
`default_nettype wire

// ===== testbench/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic              clock;       // 40 MHz
  logic              rstn;        // sync reset
  logic              active;      // power mode
  logic signed [15:0] adc_raw;    // sense word
  logic signed [15:0] adc_offset; // offset word
  wire logic [7:0]   reg_addr;    // host address
  wire logic         reg_rd;      // host read
  wire logic         reg_wr;      // host write
  wire logic [7:0]   reg_wdata;   // host data
  wire logic         cmd_end;     // host command end
  logic [7:0]        reg_rdata;   // read data
  logic              conv_done;   // period pulse
  logic              offset_cyc;  // offset running
  logic [15:0]       exp_q[$];    // {address, expected byte}
  logic [15:0]       e;           // popped note
  logic              rd_seen;     // read taken last edge
  logic [7:0]        v;           // random byte
  integer            seed;        // random seed
  int                mismatches;  // failures
  int                check_count; // comparisons
  logic [7:0] addr_tab[8] = '{8'h01, 8'h08, 8'h0e, 8'h0f, 8'h10, 8'h11, 8'h05, 8'h20};
  logic [7:0] rst_tab[8]  = '{8'h00, 8'h40, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  ccr_regs #(.HIGH_RES(1'b1), .PERIOD_HI(20), .PERIOD_LO(20), .OFS_EVERY(1024)) u_ccr_regs (
    .clock(clock), .rstn(rstn), .ce(1'b1), .active(active), .adc_raw(adc_raw),
    .adc_offset(adc_offset), .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .cmd_end(cmd_end), .reg_rdata(reg_rdata),
    .conv_done(conv_done), .offset_cyc(offset_cyc));
  ccr_host_model u_host (.clock(clock), .reg_addr(reg_addr), .reg_rd(reg_rd),
    .reg_wr(reg_wr), .reg_wdata(reg_wdata), .cmd_end(cmd_end));
  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end
  task check(input logic [7:0] a, input logic [7:0] seen, input logic [7:0] x);
    check_count++;
    if (seen !== x) begin
      mismatches++;
      $display("[FAIL] reg_rdata at %h expected %h seen %h", a, x, seen);
    end
  endtask : check
  task conclude();
    if (mismatches == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : conclude
  // read note goes on the queue before its data is checked
  task rd(input logic [7:0] a, input logic [7:0] x);
    u_host.drive(a, 1'b1, 1'b0, 8'h00, 1'b0);
    exp_q.push_back({a, x});
  endtask : rd
  task wr(input logic [7:0] a, input logic [7:0] d);
    u_host.drive(a, 1'b0, 1'b1, d, 1'b0);
  endtask : wr
  task endcmd();
    u_host.drive(8'h00, 1'b0, 1'b0, 8'h00, 1'b1);
    u_host.idle();
  endtask : endcmd
  // bounded wait for the next period pulse
  task wait_done();
    int n;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (conv_done !== 1'b1 && n < 100);
    if (n >= 100) mismatches++;
    #2;
  endtask : wait_done
  // charge write with the timer parked, so the offset period starts clean
  task commit(input logic [7:0] hi, input logic [7:0] lo);
    active = 1'b0;
    wr(8'h10, hi);
    wr(8'h11, lo);
    u_host.idle();
    active = 1'b1;
  endtask : commit
  // monitor: each read answered one cycle later against the oldest note
  always @(posedge clock) begin
    if (rd_seen && exp_q.size() > 0) begin
      e = exp_q.pop_front();
      check(e[15:8], reg_rdata, e[7:0]);
    end
    rd_seen <= reg_rd;
  end
  initial begin
    repeat (20000) @(posedge clock);
    mismatches++;
    conclude();
  end
  initial begin
    seed = 7;
    rstn = 1'b0;
    active = 1'b1;
    adc_raw = 16'sh0000;
    adc_offset = 16'sh0000;
    rd_seen = 1'b0;
    repeat (10) @(posedge clock);
    #2 rstn = 1'b1;
    foreach (addr_tab[i]) rd(addr_tab[i], rst_tab[i]);
    endcmd();
    repeat (4) begin
      v = $random(seed);
      wr(8'h01, v);
      rd(8'h01, v & 8'h50);
      wr(8'h08, v);
      rd(8'h08, v & 8'h40);
      wr(8'h0e, v);
      rd(8'h0e, 8'h00);
    end
    endcmd();
    // four adds after the forced offset leave fraction 0.5, hidden
    adc_raw = 16'sh0380;
    commit(8'h00, 8'h00);
    repeat (5) wait_done();
    rd(8'h10, 8'h00);
    rd(8'h11, 8'h03);
    endcmd();
    commit(8'h12, 8'h34);
    rd(8'h10, 8'h12);
    rd(8'h11, 8'h34);
    endcmd();
    // offset period: sense word ignored, last result still shown
    adc_raw = 16'sh7fff;
    wait_done();
    rd(8'h0e, 8'h03);
    rd(8'h0f, 8'h80);
    endcmd();
    adc_raw = 16'sh0300;
    repeat (2) wait_done();
    rd(8'h10, 8'h12);
    rd(8'h11, 8'h35);
    rd(8'h0e, 8'h03);
    rd(8'h0f, 8'h00);
    endcmd();
    // pair stays frozen across an update until the command ends
    adc_raw = 16'sh0400;
    rd(8'h10, 8'h12);
    u_host.idle();
    wait_done();
    rd(8'h11, 8'h35);
    endcmd();
    rd(8'h11, 8'h36);
    endcmd();
    active = 1'b0;
    repeat (60) @(posedge clock);
    #2;
    rd(8'h11, 8'h36);
    endcmd();
    conclude();
  end
endmodule : testbench
`default_nettype wire
